// ==== design/tm2_edge_sync.sv ====
`timescale 1ns/1ps
module tm2_edge_sync (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output wire logic fallPulse
);

  logic syncA_reg;
  logic syncB_reg;
  logic prev_reg;

  // ****************************************
  // two-stage synchroniser, then one sample of history
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= 1'h1;
      syncB_reg <= 1'h1;
      prev_reg  <= 1'h1;
    end else if (clkEn) begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
    end
  end

  // one pulse per high-to-low step of the synchronised level
  assign fallPulse = clkEn && prev_reg && !syncB_reg;

endmodule

// ==== design/tm2_timer.sv ====
`timescale 1ns/1ps
// Operation
// - overflow sets sticky overflow flag unless UART clocking
// - trigger edge causing capture/reload sets trigger flag
// - clock-select bits route this or other overflow to UART
// - trigger edges act only when enabled, no UART
// - run bit gates counting, clear holds count except trigger-edge reload
// - timer mode increments every two clocks
// - counter mode increments per count-pin falling edge
// - reload mode reloads on overflow and trigger edge
// - capture mode copies count on trigger edge
// - UART clocking forces reload on overflow
// - count bytes readable, writable, reset zero
// - reload/capture bytes readable, writable, reset zero
// - divided output toggles per overflow, gated enable
module tm2_timer (
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  input  wire logic                          clkEn,
  input  wire logic                          countPin,
  input  wire logic                          triggerPin,
  input  wire logic                          t1Overflow,
  input  wire logic [tm2_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [tm2_pkg::AXI_DW-1:0]    s_axi_wdata,
  input  wire logic [tm2_pkg::AXI_DW/8-1:0]  s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [tm2_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [tm2_pkg::AXI_DW-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               irq,
  output logic                               uartRxClk,
  output logic                               uartTxClk,
  output logic                               dividedOut,
  output logic                               dividedOutEn
);
  import tm2_pkg::*;

  function automatic logic hitIdx(input logic [AXI_AW-1:0] addr,
                                  input logic [IDX_W-1:0]  idx);
    hitIdx = (addr[AXI_AW-1:2] == {2'h0, idx});
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [REG_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] rcap_reg;
  logic             pre_reg;
  logic [IRQ_W-1:0] irqSts_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic             outEn_reg;
  logic             divOut_reg;
  logic             irq_reg;
  logic             rxClk_reg;
  logic             txClk_reg;
  logic             awRdy_reg;
  logic             wRdy_reg;
  logic             bValid_reg;
  logic [1:0]       bResp_reg;
  logic [AXI_AW-1:0] wAddr_reg;
  logic [REG_W-1:0] wData_reg;
  logic             wStrb0_reg;
  logic             arRdy_reg;
  logic             rValid_reg;
  logic [1:0]       rResp_reg;
  logic [AXI_DW-1:0] rData_reg;

  // ****************************************
  // pin edge detection
  // ****************************************
  logic cntFall;
  logic trigFall;

  tm2_edge_sync u_count_sync (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .pinIn     (countPin),
    .fallPulse (cntFall)
  );

  tm2_edge_sync u_trig_sync (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .pinIn     (triggerPin),
    .fallPulse (trigFall)
  );

  // ****************************************
  // counting decode
  // ****************************************
  wire run      = ctrl_reg[B_RUN];
  wire uartMode = ctrl_reg[B_RCLK] | ctrl_reg[B_UART_TX_CLOCK_SELECT];
  wire capMode  = ctrl_reg[B_CP] && !uartMode;
  wire tick     = ctrl_reg[B_CT] ? cntFall : (pre_reg == PRE_LAST);
  wire incr     = clkEn && run && tick;
  wire ovfEvt   = incr && (cnt_reg == CNT_MAX);
  wire ovfSet   = ovfEvt && !uartMode;
  wire trigAct  = trigFall && ctrl_reg[B_EXEN] && !uartMode;
  wire reloadNow = (ovfEvt && !capMode) || (trigAct && !capMode);
  wire capNow   = trigAct && capMode;

  // ****************************************
  // register write decode
  // ****************************************
  wire doWr    = clkEn && !awRdy_reg && !wRdy_reg && !bValid_reg;
  wire wrEn    = doWr && wStrb0_reg;
  wire wrCtrl  = wrEn && hitIdx(wAddr_reg, IDX_CTRL);
  wire wrRcL   = wrEn && hitIdx(wAddr_reg, IDX_RCAP_LO);
  wire wrRcH   = wrEn && hitIdx(wAddr_reg, IDX_RCAP_HI);
  wire wrCntL  = wrEn && hitIdx(wAddr_reg, IDX_CNT_LO);
  wire wrCntH  = wrEn && hitIdx(wAddr_reg, IDX_CNT_HI);
  wire wrSts   = wrEn && hitIdx(wAddr_reg, IDX_IRQ_STS);
  wire wrMask  = wrEn && hitIdx(wAddr_reg, IDX_IRQ_MASK);
  wire wrOut   = wrEn && hitIdx(wAddr_reg, IDX_OUT_CFG);
  wire cntWr   = wrCntL || wrCntH;
  wire wrHit   = hitIdx(wAddr_reg, IDX_CTRL) || hitIdx(wAddr_reg, IDX_RCAP_LO)
              || hitIdx(wAddr_reg, IDX_RCAP_HI) || hitIdx(wAddr_reg, IDX_CNT_LO)
              || hitIdx(wAddr_reg, IDX_CNT_HI) || hitIdx(wAddr_reg, IDX_IRQ_STS)
              || hitIdx(wAddr_reg, IDX_IRQ_MASK) || hitIdx(wAddr_reg, IDX_OUT_CFG);

  // ****************************************
  // next values
  // ****************************************
  wire [REG_W-1:0] ctrlSet  = (ovfSet ? MASK_OVF : '0) | (trigAct ? MASK_TRIG : '0);
  wire [REG_W-1:0] ctrl_next = (wrCtrl ? wData_reg : ctrl_reg) | ctrlSet;
  // software byte write wins; capture mode wraps through the plain increment
  wire [CNT_W-1:0] cnt_next = wrCntL    ? {cnt_reg[CNT_W-1:REG_W], wData_reg} :
                              wrCntH    ? {wData_reg, cnt_reg[REG_W-1:0]} :
                              reloadNow ? rcap_reg :
                              incr      ? cnt_reg + CNT_ONE : cnt_reg;
  wire [CNT_W-1:0] rcap_next = wrRcL  ? {rcap_reg[CNT_W-1:REG_W], wData_reg} :
                               wrRcH  ? {wData_reg, rcap_reg[REG_W-1:0]} :
                               capNow ? cnt_reg : rcap_reg;
  wire [IRQ_W-1:0] irqSet    = (ovfSet ? IRQ_OVF_M : '0) | (trigAct ? IRQ_TRIG_M : '0);
  wire [IRQ_W-1:0] irqClr    = wrSts ? wData_reg[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irqSts_next  = (irqSts_reg & ~irqClr) | irqSet;
  wire [IRQ_W-1:0] irqMask_next = wrMask ? wData_reg[IRQ_W-1:0] : irqMask_reg;
  wire             irq_next     = |(irqSts_next & irqMask_next);
  wire             rx_next = ctrl_reg[B_RCLK] ? ovfEvt : t1Overflow;
  wire             tx_next = ctrl_reg[B_UART_TX_CLOCK_SELECT] ? ovfEvt : t1Overflow;

  // ****************************************
  // read mux
  // ****************************************
  wire rdCtrl = hitIdx(s_axi_araddr, IDX_CTRL);
  wire rdRcL  = hitIdx(s_axi_araddr, IDX_RCAP_LO);
  wire rdRcH  = hitIdx(s_axi_araddr, IDX_RCAP_HI);
  wire rdCntL = hitIdx(s_axi_araddr, IDX_CNT_LO);
  wire rdCntH = hitIdx(s_axi_araddr, IDX_CNT_HI);
  wire rdSts  = hitIdx(s_axi_araddr, IDX_IRQ_STS);
  wire rdMask = hitIdx(s_axi_araddr, IDX_IRQ_MASK);
  wire rdOut  = hitIdx(s_axi_araddr, IDX_OUT_CFG);
  wire rdHit  = rdCtrl || rdRcL || rdRcH || rdCntL || rdCntH || rdSts || rdMask || rdOut;
  wire [REG_W-1:0] rdByte = rdCtrl ? ctrl_reg :
                            rdRcL  ? rcap_reg[REG_W-1:0] :
                            rdRcH  ? rcap_reg[CNT_W-1:REG_W] :
                            rdCntL ? cnt_reg[REG_W-1:0] :
                            rdCntH ? cnt_reg[CNT_W-1:REG_W] :
                            rdSts  ? {{(REG_W-IRQ_W){1'h0}}, irqSts_reg} :
                            rdMask ? {{(REG_W-IRQ_W){1'h0}}, irqMask_reg} :
                            rdOut  ? {{(REG_W-1){1'h0}}, outEn_reg} : '0;
  wire arTake = clkEn && s_axi_arvalid && arRdy_reg;
  wire rDone  = clkEn && s_axi_rready && rValid_reg;

  // ****************************************
  // timer core registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RST;
      cnt_reg  <= CNT_RST;
      rcap_reg <= RCAP_RST;
      pre_reg  <= 1'h0;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
      cnt_reg  <= cnt_next;
      rcap_reg <= rcap_next;
      pre_reg  <= (run && !ctrl_reg[B_CT]) ? ~pre_reg : pre_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqSts_reg  <= '0;
      irqMask_reg <= '0;
      irq_reg     <= 1'h0;
      outEn_reg   <= 1'h0;
    end else if (clkEn) begin
      irqSts_reg  <= irqSts_next;
      irqMask_reg <= irqMask_next;
      irq_reg     <= irq_next;
      outEn_reg   <= wrOut ? wData_reg[B_OUT_EN] : outEn_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divOut_reg <= 1'h0;
      rxClk_reg  <= 1'h0;
      txClk_reg  <= 1'h0;
    end else if (clkEn) begin
      divOut_reg <= divOut_reg ^ ovfEvt;
      rxClk_reg  <= rx_next;
      txClk_reg  <= tx_next;
    end
  end

  // ****************************************
  // bus slave: write channel
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awRdy_reg <= 1'h1;
      wRdy_reg  <= 1'h1;
      wAddr_reg <= '0;
    end else if (clkEn) begin
      if (s_axi_awvalid && awRdy_reg) begin
        awRdy_reg <= 1'h0;
        wAddr_reg <= s_axi_awaddr;
      end else if (s_axi_bready && bValid_reg) begin
        awRdy_reg <= 1'h1;
      end
      if (s_axi_wvalid && wRdy_reg) begin
        wRdy_reg <= 1'h0;
      end else if (s_axi_bready && bValid_reg) begin
        wRdy_reg <= 1'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wData_reg  <= '0;
      wStrb0_reg <= 1'h0;
      bValid_reg <= 1'h0;
      bResp_reg  <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_wvalid && wRdy_reg) begin
        wData_reg  <= s_axi_wdata[REG_W-1:0];
        wStrb0_reg <= s_axi_wstrb[0];
      end
      if (doWr) begin
        bValid_reg <= 1'h1;
        bResp_reg  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_reg <= 1'h0;
      end
    end
  end

  // ****************************************
  // bus slave: read channel
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arRdy_reg  <= 1'h1;
      rValid_reg <= 1'h0;
      rResp_reg  <= RESP_OKAY;
      rData_reg  <= '0;
    end else if (arTake) begin
      arRdy_reg  <= 1'h0;
      rValid_reg <= 1'h1;
      rResp_reg  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      rData_reg  <= {{(AXI_DW-REG_W){1'h0}}, rdByte};
    end else if (rDone) begin
      arRdy_reg  <= 1'h1;
      rValid_reg <= 1'h0;
    end
  end

  assign s_axi_awready = awRdy_reg;
  assign s_axi_wready  = wRdy_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = arRdy_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;
  assign irq           = irq_reg;
  assign uartRxClk     = rxClk_reg;
  assign uartTxClk     = txClk_reg;
  assign dividedOut    = divOut_reg;
  assign dividedOutEn  = outEn_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  wire quietTmr = clkEn && run && !ctrl_reg[B_CT] && !cntWr && !trigAct
                  && (cnt_reg != CNT_MAX) && !wrCtrl;

  AST_OVF_FLAG: assert property (
    ovfSet |=> ctrl_reg[B_OVF] && irqSts_reg[0])
    else $error("overflow flag not set on overflow");
  AST_TRIG_FLAG: assert property (
    trigAct |=> ctrl_reg[B_TRIG])
    else $error("trigger flag not set on trigger edge");
  AST_UART_CLK: assert property (
    clkEn |=> uartTxClk == ($past(ctrl_reg[B_UART_TX_CLOCK_SELECT]) ? $past(ovfEvt) : $past(t1Overflow)))
    else $error("transmit clock source wrong");
  AST_TRIG_IGNORED: assert property (
    clkEn && !ctrl_reg[B_EXEN] && !ctrl_reg[B_TRIG] && !wrCtrl |=> !ctrl_reg[B_TRIG])
    else $error("trigger flag set while trigger disabled");
  AST_RUN_HOLD: assert property (
    clkEn && !run && !cntWr && !trigAct |=> cnt_reg == $past(cnt_reg))
    else $error("count moved while stopped");
  AST_TIMER_RATE: assert property (
    quietTmr ##1 quietTmr |=> cnt_reg == $past(cnt_reg, 2) + CNT_ONE)
    else $error("timer mode not one step per two clocks");
  AST_COUNT_EDGE: assert property (
    clkEn && run && ctrl_reg[B_CT] && cntFall && !cntWr && !trigAct
    && (cnt_reg != CNT_MAX) |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
    else $error("counter mode edge not counted");
  AST_RELOAD: assert property (
    reloadNow && !cntWr |=> cnt_reg == $past(rcap_reg))
    else $error("reload value not loaded");
  AST_CAPTURE: assert property (
    capNow && !wrRcL && !wrRcH |=> rcap_reg == $past(cnt_reg))
    else $error("capture value not stored");
  AST_WRAP: assert property (
    ovfEvt && capMode && !cntWr && !trigAct |=> cnt_reg == CNT_RST && ctrl_reg[B_OVF])
    else $error("capture mode did not wrap to zero");
  AST_TOGGLE: assert property (
    ovfEvt |=> dividedOut != $past(dividedOut))
    else $error("divided output did not toggle");

  COV_RELOAD_OVF: cover property (ovfEvt && !capMode);
  COV_CAPTURE: cover property (capNow);
  COV_IRQ: cover property (!irq ##1 irq);
  COV_UART: cover property (uartMode && ovfEvt);

endmodule

// ==== shared/tm2_pkg.sv ====
package tm2_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int REG_W  = 8;
  localparam int CNT_W  = 16;
  localparam int IDX_W  = 8;

  // ****************************************
  // register indexes, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_CTRL     = 8'hC8;
  localparam logic [IDX_W-1:0] IDX_RCAP_LO  = 8'hCA;
  localparam logic [IDX_W-1:0] IDX_RCAP_HI  = 8'hCB;
  localparam logic [IDX_W-1:0] IDX_CNT_LO   = 8'hCC;
  localparam logic [IDX_W-1:0] IDX_CNT_HI   = 8'hCD;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS  = 8'hD0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hD1;
  localparam logic [IDX_W-1:0] IDX_OUT_CFG  = 8'hD2;

  // ****************************************
  // timer2_control fields
  // ****************************************
  localparam int B_OVF  = 7;
  localparam int B_TRIG = 6;
  localparam int B_RCLK = 5;
  localparam int B_UART_TX_CLOCK_SELECT = 4;
  localparam int B_EXEN = 3;
  localparam int B_RUN  = 2;
  localparam int B_CT   = 1;
  localparam int B_CP   = 0;
  localparam logic [REG_W-1:0] MASK_OVF  = 8'h80;
  localparam logic [REG_W-1:0] MASK_TRIG = 8'h40;

  // ****************************************
  // interrupt and output configuration fields
  // ****************************************
  localparam int IRQ_W  = 2;
  localparam logic [IRQ_W-1:0] IRQ_OVF_M  = 2'h1;
  localparam logic [IRQ_W-1:0] IRQ_TRIG_M = 2'h2;
  localparam int B_OUT_EN = 0;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] RCAP_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam int TIMER_DIV = 2;
  localparam logic PRE_LAST = 1'(TIMER_DIV - 1);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import tm2_pkg::*;
  logic              ref_clk, resetn, t1Overflow;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic [AXI_DW-1:0] wdata;
  wire logic         awready, wready, bvalid, arready, rvalid, irq;
  wire logic         uartRxClk, uartTxClk, dividedOut, dividedOutEn, countPin, triggerPin;
  wire logic [1:0]   bresp, rresp;
  wire logic [AXI_DW-1:0] rdata;
  int                miscompares, checks, seed, gap;
  logic [7:0]        v;
  logic              prevDiv;
  logic              clkEn;
  logic [1:0]        expB[$];
  logic [33:0]       expR[$];
  logic [7:0]        idxs[4];

  tm2_pin_src src (.ref_clk(ref_clk), .countPin(countPin), .triggerPin(triggerPin));

  tm2_timer DUT (
    .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .countPin(countPin),
    .triggerPin(triggerPin), .t1Overflow(t1Overflow),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .uartRxClk(uartRxClk), .uartTxClk(uartTxClk),
    .dividedOut(dividedOut), .dividedOutEn(dividedOutEn)
  );

  // ****************************************
  // clock, report and compare
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #240000;
    miscompares++;
    conclude();
  end

  task automatic cmp_bus(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_pin(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // results are taken off the queues at their handshake edges
  always @(posedge ref_clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp_bus("bresp", {32'h0, expB.pop_front()}, {32'h0, bresp});
    if (rvalid === 1'b1 && rready === 1'b1) cmp_bus("rdata", expR.pop_front(), {rresp, rdata});
  end

  // ****************************************
  // bus master
  // ****************************************
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic a, w;
    expB.push_back(er);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic a;
    expR.push_back({er, 24'h000000, d});
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    a = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (!a && arready === 1'b1) begin
        a = 1'b1;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
  endtask

  task automatic wait_tx(output int g);
    g = 0;
    do begin
      @(posedge ref_clk);
      g++;
    end while (uartTxClk !== 1'b1 && g < 100);
  endtask

  task automatic trg();
    src.pulse(1'b1, 1);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic settle_irq(input logic e);
    repeat (2) @(posedge ref_clk);
    cmp_pin("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    seed = 32'h24a5;
    clkEn = 1'b1;
    resetn = 1'b0; t1Overflow = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
    idxs = '{IDX_RCAP_LO, IDX_RCAP_HI, IDX_CNT_LO, IDX_CNT_HI};
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(IDX_CTRL, CTRL_RST);
    rd(IDX_RCAP_LO, RCAP_RST[7:0]);
    rd(IDX_RCAP_HI, RCAP_RST[15:8]);
    rd(IDX_CNT_LO, CNT_RST[7:0]);
    rd(IDX_CNT_HI, CNT_RST[15:8]);
    rd(8'hC9, 8'h00, RESP_SLVERR);
    wr(8'hC9, 8'h55, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(idxs[i], v);
      rd(idxs[i], v);
    end
    $display("test registers done");
    wr(IDX_RCAP_LO, 8'hFC); wr(IDX_RCAP_HI, 8'hFF);
    wr(IDX_CNT_LO, 8'hFC); wr(IDX_CNT_HI, 8'hFF);
    wr(IDX_OUT_CFG, 8'h01);
    wr(IDX_CTRL, 8'h34);
    wait_tx(gap);
    prevDiv = dividedOut;
    for (int k = 0; k < 2; k++) begin
      wait_tx(gap);
      cmp_pin("overflow gap", 32'd8, gap);
      cmp_pin("rx clock", 32'h1, {31'h0, uartRxClk});
      cmp_pin("divided out", {31'h0, ~prevDiv}, {31'h0, dividedOut});
      prevDiv = dividedOut;
    end
    cmp_pin("divided enable", 32'h1, {31'h0, dividedOutEn});
    rd(IDX_CTRL, 8'h34);
    rd(IDX_IRQ_STS, 8'h00);
    wr(IDX_CTRL, 8'h00);
    @(posedge ref_clk) t1Overflow <= 1'b1;
    @(posedge ref_clk) t1Overflow <= 1'b0;
    @(posedge ref_clk);
    cmp_pin("rx other", 32'h1, {31'h0, uartRxClk});
    cmp_pin("tx other", 32'h1, {31'h0, uartTxClk});
    $display("test baud done");
    wr(IDX_RCAP_LO, 8'h5A); wr(IDX_RCAP_HI, 8'h5A);
    wr(IDX_CNT_LO, 8'hFE); wr(IDX_CNT_HI, 8'hFF);
    wr(IDX_IRQ_MASK, {6'h00, IRQ_OVF_M});
    wr(IDX_CTRL, 8'h05);
    repeat (8) @(posedge ref_clk);
    rd(IDX_CTRL, 8'h85);
    rd(IDX_CNT_HI, 8'h00);
    settle_irq(1'b1);
    wr(IDX_IRQ_MASK, 8'h00);
    settle_irq(1'b0);
    wr(IDX_IRQ_MASK, {6'h00, IRQ_OVF_M});
    settle_irq(1'b1);
    wr(IDX_IRQ_STS, {6'h00, IRQ_OVF_M});
    settle_irq(1'b0);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL, 8'h00);
    $display("test overflow done");
    wr(IDX_CNT_LO, 8'h00); wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CTRL, 8'h06);
    src.pulse(1'b0, 5);
    repeat (4) @(posedge ref_clk);
    rd(IDX_CNT_LO, 8'h05);
    // clock enable low freezes the pin synchronisers and the count
    clkEn <= 1'b0;
    src.pulse(1'b0, 3);
    clkEn <= 1'b1;
    rd(IDX_CNT_LO, 8'h05);
    wr(IDX_CTRL, 8'h02);
    src.pulse(1'b0, 3);
    repeat (4) @(posedge ref_clk);
    rd(IDX_CNT_LO, 8'h05);
    $display("test counter done");
    wr(IDX_CNT_LO, 8'h34); wr(IDX_CNT_HI, 8'h12);
    wr(IDX_CTRL, 8'h0F);
    trg();
    rd(IDX_RCAP_LO, 8'h34);
    rd(IDX_RCAP_HI, 8'h12);
    rd(IDX_CTRL, 8'h4F);
    wr(IDX_CTRL, 8'h07); wr(IDX_CNT_LO, 8'h77);
    trg();
    rd(IDX_RCAP_LO, 8'h34);
    rd(IDX_CTRL, 8'h07);
    wr(IDX_CTRL, 8'h1F);
    trg();
    rd(IDX_RCAP_LO, 8'h34);
    rd(IDX_CTRL, 8'h1F);
    wr(IDX_RCAP_LO, 8'hCD); wr(IDX_RCAP_HI, 8'hAB); wr(IDX_CNT_LO, 8'h11);
    wr(IDX_IRQ_STS, 8'h03);
    wr(IDX_CTRL, 8'h0E);
    trg();
    rd(IDX_CNT_LO, 8'hCD);
    rd(IDX_CNT_HI, 8'hAB);
    rd(IDX_CTRL, 8'h4E);
    rd(IDX_IRQ_STS, {6'h00, IRQ_TRIG_M});
    wr(IDX_CTRL, 8'h00);
    $display("test trigger done");
    conclude();
  end
endmodule

// ==== tb/tm2_pin_src.sv ====
`timescale 1ns/1ps
module tm2_pin_src (
  input  wire logic ref_clk,
  output logic      countPin,
  output logic      triggerPin
);
  // ****************************************
  // pins rest high; each pulse is held long enough for sync and history
  // ****************************************
  initial begin
    countPin   = 1'b1;
    triggerPin = 1'b1;
  end

  task automatic pulse(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (sel) triggerPin <= 1'b0;
      else countPin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      triggerPin <= 1'b1;
      countPin   <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule
